/* File: omsc_pkg.sv */
/*
 * Package for the operating-mode and strap configuration block: mode codes,
 * status layout and timing counts.
 * Assumes a 50 MHz reference clock.
 */
package omsc_pkg;

	typedef enum logic [2:0] {
		MODE_INIT      = 3'h0,
		MODE_NORMAL    = 3'h1,
		MODE_STOP      = 3'h2,
		MODE_SLEEP     = 3'h3,
		MODE_RESTART   = 3'h4,
		MODE_FAIL_SAFE = 3'h5
	} omsc_mode_t;

	localparam int CLK_PERIOD_NS = 20;
	// Test pin filter time in microseconds
	localparam int TEST_PIN_FILTER_TIME_US = 64;
	localparam int TEST_PIN_FILTER_CYC = (TEST_PIN_FILTER_TIME_US * 1000) / CLK_PERIOD_NS;
	// Reset delay time in microseconds
	localparam int RESET_DELAY_TIME_US = 100;
	localparam int RESET_DELAY_CYC = (RESET_DELAY_TIME_US * 1000 + CLK_PERIOD_NS - 1)
		/ CLK_PERIOD_NS;
	// Strap filter time in microseconds
	localparam int STRAP_FILTER_TIME_US = 16;
	localparam int STRAP_FILTER_CYC = (STRAP_FILTER_TIME_US * 1000) / CLK_PERIOD_NS;

	localparam int CNT_W = 20;

	// Status word layout
	localparam int STAT_W          = 8;
	localparam int STAT_MODE_LSB   = 0;
	localparam int STAT_DEV_MODE   = 3;
	localparam int STAT_CRC_EN     = 4;
	localparam int STAT_WD_RST_EN  = 5;
	localparam int STAT_LONG_WIN   = 6;
	localparam int STAT_POR_FLAG   = 7;

	localparam logic [STAT_W-1:0] STAT_RESET = 8'h80;

endpackage : omsc_pkg

/* File: omsc_top.sv */
/*
 * Operating-mode sequencer with hardware strap capture (development mode via
 * the test pin, SPI checksum via the PWM strap pin).
 * Assumes the SPI decoder and watchdog sit outside and deliver one-cycle
 * request pulses on the reference clock; pin levels and the thermal and supply
 * monitor levels are asynchronous and are synchronised here.
 */
// How it works
// - Power-up and soft reset both lead into initialisation mode.
// - Stop mode keeps the main regulator output switched on.
// - Sleep mode switches the main regulator output off.
// - Wake from sleep/fail-safe, watchdog fail or undervoltage pass through restart.
// - Critical failure such as overtemperature forces fail-safe mode.
// - Development mode leaves every normal mode reachable.
// - Development mode: watchdog runs, failures go to interrupt, not reset.
// - Host may re-enable watchdog reset while in development mode.
// - Every watchdog start begins with the long open window.
// - Configuration and diagnosis travel over 32-bit SPI, host is master.
// - Straps accepted only in init after power-up; checksum strap also in restart.
// - After reset output release, test pin is weakly pulled high.
// - Development selection needs init from power-up, supply good, POR flag, reset high.
// - Low filtered test pin plus any SPI command latches development mode.
// - Test pin pulled up or floating selects normal operation.
// - Test pin filtered; filtered value starts at 1 on reset output rise.
// - Mode change without SPI command while monitoring cancels development mode.
// - Strap pin pulled down enables SPI checksum, else disabled.
// - Checksum strap filtered during reset delay, latched on reset output rise.
`timescale 1ns/1ns
module omsc_top
	import omsc_pkg::*;
(
	// Clock and reset
	input  wire logic                  i_ref_clk,
	input  wire logic                  i_arst_n,
	// Pins and analog monitors (asynchronous)
	input  wire logic                  i_test_pin,
	input  wire logic                  i_pwm_checksum_strap_pin,
	input  wire logic                  i_main_regulator_good,
	input  wire logic                  i_critical_fail,
	// Events from neighbouring logic (one-cycle pulses)
	input  wire logic                  i_spi_cmd_done,
	input  wire logic                  i_req_normal,
	input  wire logic                  i_req_stop,
	input  wire logic                  i_req_sleep,
	input  wire logic                  i_soft_reset,
	input  wire logic                  i_wake_event,
	input  wire logic                  i_wd_fail,
	input  wire logic                  i_wd_rst_enable,
	// Mode and pins
	output logic [2:0]                 o_mode,
	output logic                       o_main_regulator_on,
	output logic                       o_reset_output_n,
	output logic                       o_test_pin_pullup_en,
	output logic                       o_int_pulse,
	output logic                       o_wd_start_long_window,
	// Configuration and status
	output logic                       o_dev_mode,
	output logic                       o_crc_en,
	output logic [omsc_pkg::STAT_W-1:0] o_status
);
	import omsc_pkg::*;

	// Reset release through two flops
	logic rst_s1_ff, rst_n_ff;
	always_ff @(posedge i_ref_clk or negedge i_arst_n) begin
		if (!i_arst_n) begin
			rst_s1_ff <= 1'b0;
			rst_n_ff  <= 1'b0;
		end else begin
			rst_s1_ff <= 1'b1;
			rst_n_ff  <= rst_s1_ff;
		end
	end

	// Pin synchronisers; only the second stage is read
	logic [3:0] sync1_ff, sync2_ff;
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			// Idle levels: no critical failure, regulator good, both pins high
			sync1_ff <= 4'h7;
			sync2_ff <= 4'h7;
		end else begin
			sync1_ff <= {i_critical_fail, i_main_regulator_good,
				i_pwm_checksum_strap_pin, i_test_pin};
			sync2_ff <= sync1_ff;
		end
	end
	wire test_s = sync2_ff[0];
	wire strap_s = sync2_ff[1];
	wire reg_good_s = sync2_ff[2];
	wire crit_s = sync2_ff[3];

	// State
	omsc_mode_t           mode_ff, nxt_mode;
	logic                 rstout_n_ff, nxt_rstout_n;
	logic [CNT_W-1:0]     dly_ff, nxt_dly;
	logic                 from_por_ff, nxt_from_por;
	logic                 por_flag_ff, nxt_por_flag;
	logic                 tflt_ff, nxt_tflt;
	logic [CNT_W-1:0]     tcnt_ff, nxt_tcnt;
	logic                 sflt_ff, nxt_sflt;
	logic [CNT_W-1:0]     scnt_ff, nxt_scnt;
	logic                 dev_ff, nxt_dev;
	logic                 crc_ff, nxt_crc;
	logic                 wdrst_ff, nxt_wdrst;
	logic                 int_ff, nxt_int;
	logic                 lw_ff, nxt_lw;
	logic                 pu_ff, nxt_pu;

	// Development selection window open
	logic dev_window;
	logic cmd_mode_chg;
	logic wd_reset;

	always_comb begin
		nxt_mode     = mode_ff;
		nxt_rstout_n = rstout_n_ff;
		nxt_dly      = dly_ff;
		nxt_from_por = from_por_ff;
		nxt_por_flag = por_flag_ff;
		nxt_tflt     = tflt_ff;
		nxt_tcnt     = tcnt_ff;
		nxt_sflt     = sflt_ff;
		nxt_scnt     = scnt_ff;
		nxt_dev      = dev_ff;
		nxt_crc      = crc_ff;
		nxt_wdrst    = wdrst_ff;
		nxt_int      = 1'b0;
		nxt_lw       = 1'b0;
		nxt_pu       = pu_ff;
		cmd_mode_chg = i_req_normal | i_req_stop | i_req_sleep;

		wd_reset = i_wd_fail & (~dev_ff | wdrst_ff);
		if (i_wd_fail && !wd_reset) begin
			nxt_int = 1'b1;
		end
		if (dev_ff && i_wd_rst_enable) begin
			nxt_wdrst = 1'b1;
		end

		dev_window = (mode_ff == MODE_INIT) && from_por_ff && reg_good_s
			&& por_flag_ff && rstout_n_ff;

		// Test pin filter, restarts at 1 on reset rise
		if (!rstout_n_ff) begin
			nxt_tflt = 1'b1;
			nxt_tcnt = '0;
		end else if (test_s == tflt_ff) begin
			nxt_tcnt = '0;
		end else if (tcnt_ff >= CNT_W'(TEST_PIN_FILTER_CYC - 1)) begin
			nxt_tflt = test_s;
			nxt_tcnt = '0;
		end else begin
			nxt_tcnt = tcnt_ff + 1'b1;
		end

		// Strap filter runs during reset delay
		if (rstout_n_ff || strap_s == sflt_ff) begin
			nxt_scnt = '0;
		end else if (scnt_ff >= CNT_W'(STRAP_FILTER_CYC - 1)) begin
			nxt_sflt = strap_s;
			nxt_scnt = '0;
		end else begin
			nxt_scnt = scnt_ff + 1'b1;
		end

		// Low pin plus any command latches; high pin keeps normal
		if (dev_window && !tflt_ff && i_spi_cmd_done) begin
			nxt_dev = 1'b1;
		end

		// Reset output sequencing and mode machine
		if (!rstout_n_ff) begin
			if (dly_ff >= CNT_W'(RESET_DELAY_CYC - 1)) begin
				nxt_rstout_n = 1'b1;
				nxt_dly      = '0;
				// Long window on every watchdog start
				nxt_lw       = 1'b1;
				nxt_pu       = 1'b1;
				// Checksum strap latched in init-from-POR or restart
				if ((mode_ff == MODE_INIT && from_por_ff) || mode_ff == MODE_RESTART) begin
					nxt_crc = ~sflt_ff;
				end
				if (mode_ff == MODE_RESTART) begin
					nxt_mode = MODE_NORMAL;
				end
			end else begin
				nxt_dly = dly_ff + 1'b1;
			end
		end else begin
			case (mode_ff)
				MODE_INIT: begin
					if (i_req_normal) begin
						nxt_mode = MODE_NORMAL;
						nxt_por_flag = 1'b0;
						nxt_from_por = 1'b0;
					end
				end
				// All modes reachable regardless of development mode
				MODE_NORMAL: begin
					if (i_req_stop) begin
						nxt_mode = MODE_STOP;
					end else if (i_req_sleep) begin
						nxt_mode = MODE_SLEEP;
					end
				end
				MODE_STOP: begin
					if (i_req_normal) begin
						nxt_mode = MODE_NORMAL;
					end
				end
				// Wake from sleep or fail-safe goes to restart
				MODE_SLEEP, MODE_FAIL_SAFE: begin
					if (i_wake_event && !(mode_ff == MODE_FAIL_SAFE && crit_s)) begin
						nxt_mode = MODE_RESTART;
						nxt_rstout_n = 1'b0;
					end
				end
				default: begin
					nxt_mode = MODE_RESTART;
				end
			endcase
			if ((wd_reset || !reg_good_s) && mode_ff != MODE_SLEEP
				&& mode_ff != MODE_FAIL_SAFE) begin
				nxt_mode = MODE_RESTART;
				nxt_rstout_n = 1'b0;
			end
		end

		if (i_soft_reset) begin
			nxt_mode = MODE_INIT;
			nxt_rstout_n = 1'b0;
			nxt_dly = '0;
		end
		if (crit_s) begin
			nxt_mode = MODE_FAIL_SAFE;
			nxt_rstout_n = 1'b0;
		end
		// No watchdog start while an override holds the reset output low
		if (!nxt_rstout_n) begin
			nxt_pu = 1'b0;
			nxt_lw = 1'b0;
		end
		// Uncommanded mode change while monitoring drops development mode
		if (from_por_ff && nxt_mode != mode_ff && !cmd_mode_chg) begin
			nxt_dev = 1'b0;
		end
	end

	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			mode_ff     <= MODE_INIT;
			rstout_n_ff <= 1'b0;
			dly_ff      <= '0;
			from_por_ff <= 1'b1;
			por_flag_ff <= 1'b1;
			tflt_ff     <= 1'b1;
			tcnt_ff     <= '0;
			sflt_ff     <= 1'b1;
			scnt_ff     <= '0;
			dev_ff      <= 1'b0;
			crc_ff      <= 1'b0;
			wdrst_ff    <= 1'b0;
			int_ff      <= 1'b0;
			lw_ff       <= 1'b0;
			pu_ff       <= 1'b0;
		end else begin
			mode_ff     <= nxt_mode;
			rstout_n_ff <= nxt_rstout_n;
			dly_ff      <= nxt_dly;
			from_por_ff <= nxt_from_por;
			por_flag_ff <= nxt_por_flag;
			tflt_ff     <= nxt_tflt;
			tcnt_ff     <= nxt_tcnt;
			sflt_ff     <= nxt_sflt;
			scnt_ff     <= nxt_scnt;
			dev_ff      <= nxt_dev;
			crc_ff      <= nxt_crc;
			wdrst_ff    <= nxt_wdrst;
			int_ff      <= nxt_int;
			lw_ff       <= nxt_lw;
			pu_ff       <= nxt_pu;
		end
	end

	// Registered outputs; regulator decoded one cycle ahead from next mode
	logic reg_on_ff;
	logic [STAT_W-1:0] stat_ff;
	always_ff @(posedge i_ref_clk or negedge rst_n_ff) begin
		if (!rst_n_ff) begin
			reg_on_ff <= 1'b1;
			stat_ff   <= STAT_RESET;
		end else begin
			reg_on_ff <= (nxt_mode != MODE_SLEEP);
			// Status field for the SPI read path
			stat_ff <= {nxt_por_flag, nxt_lw, nxt_wdrst, nxt_crc, nxt_dev, nxt_mode};
		end
	end

	assign o_mode                 = mode_ff;
	assign o_main_regulator_on    = reg_on_ff;
	assign o_reset_output_n       = rstout_n_ff;
	assign o_test_pin_pullup_en   = pu_ff;
	assign o_int_pulse            = int_ff;
	assign o_wd_start_long_window = lw_ff;
	assign o_dev_mode             = dev_ff;
	assign o_crc_en               = crc_ff;
	assign o_status               = stat_ff;

endmodule : omsc_top

/* File: omsc_top_properties.sv */
/* Port checker for the mode sequencer, bound into every omsc_top.
   Assumes one clock domain and the asynchronous active-low reset. */
`timescale 1ns/1ns
module omsc_top_chk (
	// Clock, reset and events
	input wire logic       i_ref_clk,
	input wire logic       i_arst_n,
	input wire logic       i_critical_fail,
	input wire logic       i_main_regulator_good,
	input wire logic       i_soft_reset,
	input wire logic       i_wake_event,
	input wire logic       i_wd_fail,
	// Outputs watched
	input wire logic [2:0] o_mode,
	input wire logic       o_main_regulator_on,
	input wire logic       o_reset_output_n,
	input wire logic       o_test_pin_pullup_en,
	input wire logic       o_int_pulse,
	input wire logic       o_wd_start_long_window,
	input wire logic       o_dev_mode,
	input wire logic       o_crc_en,
	input wire logic [7:0] o_status
);
	default clocking cb @(posedge i_ref_clk); endclocking
	default disable iff (!i_arst_n);
	property p_stop_reg; o_mode == 3'h2 |-> o_main_regulator_on; endproperty
	a_stop_reg: assert property (p_stop_reg) else $error("regulator off in stop");
	property p_sleep_reg; o_mode == 3'h3 |-> !o_main_regulator_on; endproperty
	a_sleep_reg: assert property (p_sleep_reg) else $error("regulator on in sleep");
	property p_soft_init;
		i_soft_reset && !$past(i_critical_fail, 2) && o_mode != 3'h5 |=> o_mode == 3'h0;
	endproperty
	a_soft_init: assert property (p_soft_init) else $error("soft reset missed init");
	property p_wake;
		o_mode == 3'h3 && i_wake_event && !$past(i_critical_fail, 2) && !i_soft_reset
		|=> o_mode == 3'h4 && !o_reset_output_n;
	endproperty
	a_wake: assert property (p_wake) else $error("wake did not restart");
	property p_rst_low; o_mode == 3'h4 |-> !o_reset_output_n; endproperty
	a_rst_low: assert property (p_rst_low) else $error("restart without reset");
	property p_dev_int;
		o_dev_mode && i_wd_fail && !o_status[5] && o_reset_output_n && !i_soft_reset
		&& !i_wake_event && !$past(i_critical_fail, 2) && $past(i_main_regulator_good, 2)
		|=> o_int_pulse && o_reset_output_n ##1 !o_int_pulse;
	endproperty
	a_dev_int: assert property (p_dev_int) else $error("dev watchdog fail wrong");
	property p_pullup;
		o_reset_output_n && $past(o_reset_output_n) |-> o_test_pin_pullup_en;
	endproperty
	a_pullup: assert property (p_pullup) else $error("test pin pull-up off");
	property p_long_win; $rose(o_reset_output_n) |-> ##[0:1] o_wd_start_long_window; endproperty
	a_long_win: assert property (p_long_win) else $error("no long window start");
	property p_status;
		o_status[2:0] == o_mode && o_status[3] == o_dev_mode && o_status[4] == o_crc_en;
	endproperty
	a_status: assert property (p_status) else $error("status field mismatch");
	c_dev: cover property ($rose(o_dev_mode));
	c_sleep: cover property (o_mode == 3'h3);
	c_fail_safe: cover property (o_mode == 3'h5);
endmodule : omsc_top_chk
bind omsc_top omsc_top_chk CHK (.*);

/* File: omsc_host_model.sv */
/* Far-side model: board strap resistors and the host interrupt counter.
   Assumes the strap pin idles high inside the device when left open. */
`timescale 1ns/1ns
module omsc_host_model (
	// Board choices and device pins
	input  wire logic i_ref_clk,
	input  wire logic i_test_pd,
	input  wire logic i_strap_pd,
	input  wire logic i_pullup_en,
	input  wire logic i_int,
	// Pin levels and host view
	output logic      o_test_lvl,
	output logic      o_strap_lvl,
	output int        o_int_cnt
);
	// An open pin with no pull reads as noise, never a steady value
	logic flt_ff = 1'h0;
	always_ff @(posedge i_ref_clk) flt_ff <= !flt_ff;
	assign o_test_lvl = i_test_pd ? 1'h0 : (i_pullup_en ? 1'h1 : flt_ff);
	assign o_strap_lvl = !i_strap_pd;
	always_ff @(posedge i_ref_clk) if (i_int) o_int_cnt <= o_int_cnt + 1;
endmodule : omsc_host_model

/* File: tb_top.sv */
/* Self-checking bench: power-up, development mode, power saving, restart
   and failures. Assumes the package timing constants as delivered. */
`timescale 1ns/1ns
module tb_top;
	import omsc_pkg::*;
	logic i_ref_clk = 1'h0, i_arst_n = 1'h0, i_test_pin, i_pwm_checksum_strap_pin;
	logic i_main_regulator_good = 1'h1, i_critical_fail = 1'h0, i_spi_cmd_done = 1'h0;
	logic i_req_normal = 1'h0, i_req_stop = 1'h0, i_req_sleep = 1'h0, i_soft_reset = 1'h0;
	logic i_wake_event = 1'h0, i_wd_fail = 1'h0, i_wd_rst_enable = 1'h0;
	logic [2:0] o_mode;
	logic o_main_regulator_on, o_reset_output_n, o_test_pin_pullup_en, o_int_pulse;
	logic o_wd_start_long_window, o_dev_mode, o_crc_en;
	logic [STAT_W-1:0] o_status;
	logic test_pd = 1'h1, strap_pd = 1'h1;
	logic [2:0] exp_m [4] = '{MODE_NORMAL, MODE_STOP, MODE_NORMAL, MODE_SLEEP};
	int fail_count = 0, checks = 0, int_seen;
	int lw_seen = 0;
	always #10 i_ref_clk = ~i_ref_clk;
	// Count watchdog start pulses, each visible for one cycle
	always @(posedge i_ref_clk) if (o_wd_start_long_window) lw_seen++;
	omsc_top DUT (.*);
	omsc_host_model HOST (.i_ref_clk, .i_test_pd(test_pd), .i_strap_pd(strap_pd),
		.i_pullup_en(o_test_pin_pullup_en), .i_int(o_int_pulse), .o_test_lvl(i_test_pin),
		.o_strap_lvl(i_pwm_checksum_strap_pin), .o_int_cnt(int_seen));
	task automatic check(input string nm, input logic [7:0] seen, input logic [7:0] exp);
		checks++;
		if (seen !== exp) begin
			fail_count++;
			$display("wrong value %s expected %h seen %h", nm, exp, seen);
		end
	endtask : check
	task automatic stop_test;
		$display("checks %0d mismatches %0d", checks, fail_count);
		if (fail_count == 0 && checks > 0) $display("DONE - PASS");
		else $display("DONE - FAIL");
		$finish;
	endtask : stop_test
	// One-cycle event pulse; its answer is visible at the second falling edge
	task automatic pulse(ref logic s);
		@(negedge i_ref_clk) s = 1'h1;
		@(negedge i_ref_clk) s = 1'h0;
	endtask : pulse
	task automatic wait_rst_hi;
		int n = 0;
		while (o_reset_output_n !== 1'h1) begin
			@(negedge i_ref_clk);
			n++;
			if (n > RESET_DELAY_CYC + 100) begin
				fail_count++;
				stop_test();
			end
		end
		repeat (2) @(negedge i_ref_clk);
	endtask : wait_rst_hi
	initial begin
		repeat (6) @(negedge i_ref_clk);
		check("mode", o_mode, MODE_INIT);
		check("status", o_status, STAT_RESET);
		i_arst_n = 1'h1;
		wait_rst_hi();
		check("crc", o_crc_en, 1'h1);
		check("pullup", o_test_pin_pullup_en, 1'h1);
		check("long window", lw_seen, 8'h01);
		$display("test power-up finished");
		repeat (TEST_PIN_FILTER_CYC + 10) @(negedge i_ref_clk);
		pulse(i_spi_cmd_done);
		check("dev", o_dev_mode, 1'h1);
		check("dev status", o_status[STAT_DEV_MODE], 1'h1);
		pulse(i_wd_fail);
		repeat (2) @(negedge i_ref_clk);
		check("interrupts", int_seen, 8'h01);
		check("reset out", o_reset_output_n, 1'h1);
		$display("test development mode finished");
		for (int k = 0; k < 4; k++) begin
			case (k)
			0, 2: pulse(i_req_normal);
			1: pulse(i_req_stop);
			default: pulse(i_req_sleep);
			endcase
			check("mode", o_mode, exp_m[k]);
			check("regulator", o_main_regulator_on, k != 3);
		end
		check("por flag", o_status[STAT_POR_FLAG], 1'h0);
		$display("test power saving finished");
		strap_pd = 1'h0;
		pulse(i_wake_event);
		check("mode", o_mode, MODE_RESTART);
		check("reset out", o_reset_output_n, 1'h0);
		wait_rst_hi();
		check("mode", o_mode, MODE_NORMAL);
		check("crc", o_crc_en, 1'h0);
		check("long window", lw_seen, 8'h02);
		@(negedge i_ref_clk) i_main_regulator_good = 1'h0;
		repeat (4) @(negedge i_ref_clk);
		check("mode", o_mode, MODE_RESTART);
		check("reset out", o_reset_output_n, 1'h0);
		i_main_regulator_good = 1'h1;
		wait_rst_hi();
		check("mode", o_mode, MODE_NORMAL);
		$display("test restart finished");
		pulse(i_wd_rst_enable);
		check("wd reset", o_status[STAT_WD_RST_EN], 1'h1);
		pulse(i_wd_fail);
		check("mode", o_mode, MODE_RESTART);
		pulse(i_soft_reset);
		check("mode", o_mode, MODE_INIT);
		@(negedge i_ref_clk) i_critical_fail = 1'h1;
		repeat (4) @(negedge i_ref_clk);
		check("mode", o_mode, MODE_FAIL_SAFE);
		$display("test failures finished");
		stop_test();
	end
endmodule : tb_top
